// ---- common/slc_pkg.sv ----
// serdes lane-1 configuration bank: offsets, field positions, resets
// assumes one 32-bit AHB-Lite register bus; no other dependencies
package slc_pkg;

    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int NUM_PORTS = 4;
    localparam int ADDR_W    = 20;
    localparam int DATA_W    = 32;

    // byte offsets of lane1_config_port0/2/4/6
    localparam logic [ADDR_W-1:0] OFF_PORT0 = 20'h130B4;
    localparam logic [ADDR_W-1:0] OFF_PORT2 = 20'h132B4;
    localparam logic [ADDR_W-1:0] OFF_PORT4 = 20'h134B4;
    localparam logic [ADDR_W-1:0] OFF_PORT6 = 20'h136B4;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int HALF_RATE_BIT   = 0;
    localparam int TX_RECOMP_BIT   = 1;
    localparam int SPARE_LO        = 2;
    localparam int FIXED_ZERO_BIT  = 8;
    localparam int TX_EN_LO        = 9;
    localparam int TX_BOOST_LO     = 12;
    localparam int RX_PLL_PWR_BIT  = 16;
    localparam int RX_EN_BIT       = 17;
    localparam int DPLL_CLR_BIT    = 18;
    localparam int EQ_LO           = 21;
    localparam int DPLL_MODE_LO    = 24;
    localparam int TX_CLK_PWR_BIT  = 27;
    localparam int LOS_LO          = 28;
    localparam int ALIGN_BIT       = 30;

    // ****************************************************************
    // codes and resets
    // ****************************************************************
    localparam logic [2:0] TX_EN_OFF  = 3'h0;
    localparam logic [2:0] TX_EN_FULL = 3'h3;
    localparam logic [1:0] LOS_OFF    = 2'h0;
    localparam logic [1:0] LOS_HEAVY  = 2'h3;

    // half rate bit (bit 0) taken from HALF_RATE_RST at the top
    localparam logic [DATA_W-1:0] CFG_RST     = 32'hC8A7_C610;
    localparam logic [DATA_W-1:0] WR_MASK     = 32'hFFFF_FEFF;
    localparam logic [DATA_W-1:0] LOCKED_MASK = 32'h0003_0E00;

endpackage : slc_pkg

// ---- common/slc_lane_if.sv ----
// per-port control level and its one-cycle edge pulse
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface slc_lane_if #(parameter int N = 4);
    logic [N-1:0] trig_level;
    logic [N-1:0] trig_pulse;
    modport src (output trig_level, input trig_pulse);
    modport det (input trig_level, output trig_pulse);
endinterface : slc_lane_if

// ---- verilog/slc_sync2.sv ----
// two-flop synchroniser for asynchronous status pins
// assumes the input may change at any time relative to core_clk
`timescale 1ns/1ps
module slc_sync2 #(
    parameter int N = 4
) (
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    input  wire logic [N-1:0] d_async,
    output logic      [N-1:0] q_sync
);
    typedef struct packed {
        logic [N-1:0] meta;
        logic [N-1:0] stable;
    } slc_sync_s;

    slc_sync_s st_reg;
    slc_sync_s st_next;

    always_comb begin
        st_next        = st_reg;
        st_next.meta   = d_async;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_sync = st_reg.stable;
endmodule // slc_sync2

// ---- verilog/slc_edge.sv ----
// registered rising-edge detector, one per port
// assumes the level comes from flops on the same clock
`timescale 1ns/1ps
module slc_edge #(
    parameter int         N        = 4,
    parameter logic [3:0] PREV_RST = 4'h0
) (
    input  wire logic core_clk,
    input  wire logic arst_n,
    slc_lane_if.det   lane
);
    typedef struct packed {
        logic [N-1:0] prev;
        logic [N-1:0] pulse;
    } slc_edge_s;

    slc_edge_s st_reg;
    slc_edge_s st_next;

    always_comb begin
        st_next       = st_reg;
        st_next.prev  = lane.trig_level;
        st_next.pulse = lane.trig_level & ~st_reg.prev;
    end

    // prev resets to the bit's own reset so release gives no pulse
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.prev  <= PREV_RST[N-1:0];
            st_reg.pulse <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lane.trig_pulse = st_reg.pulse;
endmodule // slc_edge

// ---- verilog/slc_top.sv ----
// lane-1 configuration register bank for four serial ports
// assumes an AHB-Lite master with one slave; bypass_init comes
// from the global config on core_clk, lock pins are asynchronous
//
// How it works
// - four copies at 130B4, 132B4, 134B4, 136B4
// - bit 0 selects half (1.25G) rate
// - bit 1 rising edge recomputes transmitter
// - bit 18 rising edge clears DPLL frequency
// - transmitter enable 000 off, 011 on
// - transmit and receive enables and receive PLL power writable only with bypass_init set
// - bit 16 powers receive PLL
// - bit 17 enables receive clock and data
// - receive enable needs PLL power and lock
// - bits 12:15 set transmit boost
// - bits 21:23 set equaliser level
// - bit 27 powers transmit clock domain
// - bits 28:29 loss-of-signal filter, 00 or 11
// - bit 30 enables word alignment framer
`timescale 1ns/1ps
module slc_top
    import slc_pkg::*;
#(
    parameter logic HALF_RATE_RST = 1'b0
) (
    input  wire logic                                   core_clk,
    input  wire logic                                   arst_n,
    input  wire logic                                   hsel,
    input  wire logic [slc_pkg::ADDR_W-1:0]             haddr,
    input  wire logic [1:0]                             htrans,
    input  wire logic                                   hwrite,
    input  wire logic [2:0]                             hsize,
    input  wire logic [slc_pkg::DATA_W-1:0]             hwdata,
    input  wire logic                                   hready,
    output logic                                        hreadyout,
    output logic                                        hresp,
    output logic      [slc_pkg::DATA_W-1:0]             hrdata,
    input  wire logic [slc_pkg::NUM_PORTS-1:0]          bypass_init,
    input  wire logic [slc_pkg::NUM_PORTS-1:0]          rx_pll_lock_async,
    output logic      [slc_pkg::NUM_PORTS-1:0]          half_rate,
    output logic      [slc_pkg::NUM_PORTS-1:0]          tx_recompute_trigger,
    output logic      [slc_pkg::NUM_PORTS-1:0][2:0]     tx_enable,
    output logic      [slc_pkg::NUM_PORTS-1:0][3:0]     tx_boost,
    output logic      [slc_pkg::NUM_PORTS-1:0]          rx_pll_power,
    output logic      [slc_pkg::NUM_PORTS-1:0]          rx_enable,
    output logic      [slc_pkg::NUM_PORTS-1:0]          dpll_frequency_clear,
    output logic      [slc_pkg::NUM_PORTS-1:0][2:0]     receive_equaliser_level,
    output logic      [slc_pkg::NUM_PORTS-1:0][2:0]     dpll_mode_select,
    output logic      [slc_pkg::NUM_PORTS-1:0]          transmit_clock_power,
    output logic      [slc_pkg::NUM_PORTS-1:0][1:0]     signal_loss_filter_control,
    output logic      [slc_pkg::NUM_PORTS-1:0]          word_align_enable
);
    import slc_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [NUM_PORTS-1:0][DATA_W-1:0] cfg;
        logic                             wr_pend;
        logic [1:0]                       wr_idx;
        logic [DATA_W-1:0]                rd_data;
        logic [NUM_PORTS-1:0]             rx_en_q;
    } slc_top_s;

    slc_top_s st_reg;
    slc_top_s st_next;

    logic [NUM_PORTS-1:0] lock_sync;
    logic                 acc_valid;
    logic [2:0]           dec;
    logic                 dec_hit;
    logic [1:0]           dec_idx;

    // ****************************************************************
    // helpers
    // ****************************************************************

    // {hit, port index}; unmapped addresses give hit = 0
    function automatic logic [2:0] slc_decode(input logic [ADDR_W-1:0] a);
        logic [2:0] r;
        r = 3'h0;
        unique case (a)
            OFF_PORT0: r = 3'h4;
            OFF_PORT2: r = 3'h5;
            OFF_PORT4: r = 3'h6;
            OFF_PORT6: r = 3'h7;
            default:   r = 3'h0;
        endcase
        return r;
    endfunction

    // only off and fully on may reach the transmitter
    function automatic logic slc_txen_legal(
        input logic [2:0] code
    );
        return (code == TX_EN_OFF) || (code == TX_EN_FULL);
    endfunction

    // 01 and 10 are reserved filter settings
    function automatic logic slc_los_legal(
        input logic [1:0] code
    );
        return (code == LOS_OFF) || (code == LOS_HEAVY);
    endfunction

    // receive side may run only with PLL power and lock
    function automatic logic slc_rx_allowed(
        input logic [DATA_W-1:0] w,
        input logic              locked
    );
        return w[RX_PLL_PWR_BIT] & locked;
    endfunction

    // merge one bus write into a lane word
    function automatic logic [DATA_W-1:0] slc_merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] wd,
        input logic              bypass,
        input logic              locked
    );
        logic [DATA_W-1:0] nw;
        logic [2:0]        txc;
        logic [1:0]        losc;
        nw = (old_w & ~WR_MASK) | (wd & WR_MASK);
        if (!bypass) begin
            nw = (nw & ~LOCKED_MASK) | (old_w & LOCKED_MASK);
        end
        txc = nw[TX_EN_LO +: 3];
        if (!slc_txen_legal(txc)) begin
            // reserved codes never reach the transmitter
            nw[TX_EN_LO +: 3] = old_w[TX_EN_LO +: 3];
        end
        losc = nw[LOS_LO +: 2];
        if (!slc_los_legal(losc)) begin
            nw[LOS_LO +: 2] = old_w[LOS_LO +: 2];
        end
        if (nw[RX_EN_BIT] && !old_w[RX_EN_BIT] && !slc_rx_allowed(nw, locked)) begin
            // assertion refused until the PLL is up and locked
            nw[RX_EN_BIT] = 1'b0;
        end
        return nw;
    endfunction

    // ****************************************************************
    // lock pin synchroniser
    // ****************************************************************
    slc_sync2 #(
        .N (NUM_PORTS)
    ) u_lock_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .d_async  (rx_pll_lock_async),
        .q_sync   (lock_sync)
    );

    // ****************************************************************
    // bus decode
    // ****************************************************************

    // zero wait state: the slave never stretches a transfer
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign acc_valid = hsel & hready & htrans[1];
    assign dec       = slc_decode(haddr);
    assign dec_hit   = dec[2];
    assign dec_idx   = dec[1:0];

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next         = st_reg;
        st_next.wr_pend = 1'b0;

        // data phase of a write: hwdata is valid now
        if (st_reg.wr_pend) begin
            st_next.cfg[st_reg.wr_idx] = slc_merge(
                st_reg.cfg[st_reg.wr_idx],
                hwdata,
                bypass_init[st_reg.wr_idx],
                lock_sync[st_reg.wr_idx]);
        end

        if (acc_valid) begin
            if (hwrite) begin
                // unmapped writes are dropped with an OKAY answer
                st_next.wr_pend = dec_hit;
                st_next.wr_idx  = dec_idx;
            end else if (dec_hit) begin
                // read from the merged word so a write just ahead is seen
                st_next.rd_data = st_next.cfg[dec_idx];
            end else begin
                st_next.rd_data = '0;
            end
        end

        for (int i = 0; i < NUM_PORTS; i++) begin
            st_next.rx_en_q[i] = st_reg.cfg[i][RX_EN_BIT]
                               & slc_rx_allowed(st_reg.cfg[i],
                                                lock_sync[i]);
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                st_reg.cfg[i] <= {CFG_RST[DATA_W-1:1], HALF_RATE_RST};
            end
            st_reg.wr_pend <= 1'b0;
            st_reg.wr_idx  <= 2'h0;
            st_reg.rd_data <= '0;
            st_reg.rx_en_q <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata = st_reg.rd_data;

    // ****************************************************************
    // edge-triggered controls
    // ****************************************************************
    slc_lane_if #(.N(NUM_PORTS)) calc_if ();
    slc_lane_if #(.N(NUM_PORTS)) dpll_if ();

    // transmitter recompute bit resets to 0
    slc_edge #(
        .N        (NUM_PORTS),
        .PREV_RST (4'h0)
    ) u_calc_edge (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .lane     (calc_if.det)
    );

    // dpll clear bit resets to 1, so release alone makes no edge
    slc_edge #(
        .N        (NUM_PORTS),
        .PREV_RST (4'hF)
    ) u_dpll_edge (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .lane     (dpll_if.det)
    );

    assign tx_recompute_trigger = calc_if.trig_pulse;
    assign dpll_frequency_clear = dpll_if.trig_pulse;

    // ****************************************************************
    // lane outputs
    // ****************************************************************
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_lane
        assign calc_if.trig_level[g]          = st_reg.cfg[g][TX_RECOMP_BIT];
        assign dpll_if.trig_level[g]          = st_reg.cfg[g][DPLL_CLR_BIT];
        assign half_rate[g]                   = st_reg.cfg[g][HALF_RATE_BIT];
        assign tx_enable[g]                   = st_reg.cfg[g][TX_EN_LO +: 3];
        assign tx_boost[g]                    = st_reg.cfg[g][TX_BOOST_LO +: 4];
        assign rx_pll_power[g]                = st_reg.cfg[g][RX_PLL_PWR_BIT];
        assign rx_enable[g]                   = st_reg.rx_en_q[g];
        assign receive_equaliser_level[g]     = st_reg.cfg[g][EQ_LO +: 3];
        // mode changes while enabled are software's to avoid
        assign dpll_mode_select[g]            = st_reg.cfg[g][DPLL_MODE_LO +: 3];
        assign transmit_clock_power[g]        = st_reg.cfg[g][TX_CLK_PWR_BIT];
        assign signal_loss_filter_control[g]  = st_reg.cfg[g][LOS_LO +: 2];
        assign word_align_enable[g]           = st_reg.cfg[g][ALIGN_BIT];
    end

endmodule // slc_top

// ---- verification/slc_top_checker.sv ----
// checker for the lane-1 configuration bank, bound into slc_top
// assumes one clock domain and the top module's port names
`timescale 1ns/1ps
module slc_checker
    import slc_pkg::*;
(
    input wire logic                               core_clk,
    input wire logic                               arst_n,
    input wire logic                               hsel,
    input wire logic [1:0]                         htrans,
    input wire logic                               hwrite,
    input wire logic                               hready,
    input wire logic                               hreadyout,
    input wire logic                               hresp,
    input wire logic [slc_pkg::DATA_W-1:0]         hrdata,
    input wire logic [slc_pkg::NUM_PORTS-1:0]      bypass_init,
    input wire logic [slc_pkg::NUM_PORTS-1:0]      rx_pll_lock_async,
    input wire logic [slc_pkg::NUM_PORTS-1:0]      tx_recompute_trigger,
    input wire logic [slc_pkg::NUM_PORTS-1:0][2:0] tx_enable,
    input wire logic [slc_pkg::NUM_PORTS-1:0]      rx_pll_power,
    input wire logic [slc_pkg::NUM_PORTS-1:0]      rx_enable,
    input wire logic [slc_pkg::NUM_PORTS-1:0]      dpll_frequency_clear,
    input wire logic [slc_pkg::NUM_PORTS-1:0][1:0] signal_loss_filter_control
);
    import slc_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic txen_ok;
    logic los_ok;
    always_comb begin
        txen_ok = 1'b1;
        los_ok  = 1'b1;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (tx_enable[p] != TX_EN_OFF && tx_enable[p] != TX_EN_FULL) txen_ok = 1'b0;
            if (signal_loss_filter_control[p] != LOS_OFF && signal_loss_filter_control[p] != LOS_HEAVY) los_ok = 1'b0;
        end
    end
    property p_bus_okay; hreadyout && !hresp; endproperty
    property p_txen_code; txen_ok; endproperty
    property p_los_code; los_ok; endproperty
    // lock pin reaches rx_enable through two sync flops and one register
    property p_rx_en_lock; (rx_enable & ~$past(rx_enable) & ~$past(rx_pll_lock_async, 3)) == '0; endproperty
    property p_rx_en_power; (rx_enable & ~(rx_pll_power | $past(rx_pll_power))) == '0; endproperty
    property p_tx_pulse; (tx_recompute_trigger & $past(tx_recompute_trigger)) == '0; endproperty
    property p_dpll_pulse; (dpll_frequency_clear & $past(dpll_frequency_clear)) == '0; endproperty
    property p_locked_fields;
        (tx_enable != $past(tx_enable)) || (rx_pll_power != $past(rx_pll_power))
            |-> ($past(bypass_init) | $past(bypass_init, 2)) != '0;
    endproperty
    property p_rdata_hold; !$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata); endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
    a_txen_code: assert property (p_txen_code) else $error("reserved transmitter enable code");
    a_los_code: assert property (p_los_code) else $error("reserved loss filter code");
    a_rx_en_lock: assert property (p_rx_en_lock) else $error("receive enabled without lock");
    a_rx_en_power: assert property (p_rx_en_power) else $error("receive enabled without pll power");
    a_tx_pulse: assert property (p_tx_pulse) else $error("recompute pulse too long");
    a_dpll_pulse: assert property (p_dpll_pulse) else $error("dpll clear pulse too long");
    a_locked_fields: assert property (p_locked_fields) else $error("locked field changed");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
    c_tx_pulse: cover property (|tx_recompute_trigger);
    c_dpll_pulse: cover property (|dpll_frequency_clear);
    c_rx_en_rise: cover property ($rose(|rx_enable));
endmodule // slc_checker

bind slc_top slc_checker u_chk (.core_clk, .arst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .hrdata, .bypass_init, .rx_pll_lock_async, .tx_recompute_trigger, .tx_enable, .rx_pll_power, .rx_enable,
    .dpll_frequency_clear, .signal_loss_filter_control);

// ---- verification/tb_serdes_lane_config_register.sv ----
// self-checking bench for slc_top over AHB-Lite
// assumes the bound checker and slc_pkg constants
`timescale 1ns/1ps
module tb_serdes_lane_config_register;
    import slc_pkg::*;
    logic                          core_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp, rd_ph;
    logic [ADDR_W-1:0]             haddr;
    logic [1:0]                    htrans;
    logic [2:0]                    hsize;
    logic [DATA_W-1:0]             hwdata, hrdata, d;
    logic [NUM_PORTS-1:0]          bypass_init, rx_pll_lock_async, half_rate, tx_recompute_trigger;
    logic [NUM_PORTS-1:0]          rx_pll_power, rx_enable, dpll_frequency_clear, transmit_clock_power;
    logic [NUM_PORTS-1:0]          word_align_enable;
    logic [NUM_PORTS-1:0][2:0]     tx_enable, receive_equaliser_level, dpll_mode_select;
    logic [NUM_PORTS-1:0][3:0]     tx_boost;
    logic [NUM_PORTS-1:0][1:0]     signal_loss_filter_control;
    logic [DATA_W-1:0]             m [4];
    logic [DATA_W-1:0]             exq [$];
    logic [ADDR_W-1:0]             offs [4] = '{OFF_PORT0, OFF_PORT2, OFF_PORT4, OFF_PORT6};
    int                            errors, compares, seed, tx_cnt [4], dp_cnt [4], s1, s2;
    assign hready = hreadyout;
    slc_top dut_u (.core_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
        .hresp, .hrdata, .bypass_init, .rx_pll_lock_async, .half_rate, .tx_recompute_trigger, .tx_enable,
        .tx_boost, .rx_pll_power, .rx_enable, .dpll_frequency_clear, .receive_equaliser_level,
        .dpll_mode_select, .transmit_clock_power, .signal_loss_filter_control, .word_align_enable);
    always #2 core_clk = ~core_clk;
    // ****************************************
    // reference model and bus tasks
    // ****************************************
    function automatic logic [31:0] mdl(logic [31:0] o, logic [31:0] w, logic b, logic l);
        logic [31:0] n;
        n = w & WR_MASK;
        if (!b) n = (n & ~LOCKED_MASK) | (o & LOCKED_MASK);
        if (n[11:9] != TX_EN_OFF && n[11:9] != TX_EN_FULL) n[11:9] = o[11:9];
        if (n[29:28] == 2'h1 || n[29:28] == 2'h2) n[29:28] = o[29:28];
        if (!o[17] && n[17] && !(n[16] && l)) n[17] = 1'b0;
        return n;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
    endtask
    task automatic wr(input int p, input logic [31:0] wd);
        m[p] = mdl(m[p], wd, bypass_init[p], rx_pll_lock_async[p]);
        bus(1'b1, offs[p], wd);
    endtask
    task automatic rd(input int p);
        exq.push_back(m[p]);
        bus(1'b0, offs[p], 32'h0);
    endtask
    task automatic chk_out(input int p);
        repeat (3) @(posedge core_clk);
        #1;
        cmp({12'h0, word_align_enable[p], signal_loss_filter_control[p], transmit_clock_power[p],
             dpll_mode_select[p], receive_equaliser_level[p], rx_pll_power[p], tx_boost[p], tx_enable[p],
             half_rate[p], rx_enable[p]}, {12'h0, m[p][30:21], m[p][16:9], m[p][0],
             m[p][17] & m[p][16] & rx_pll_lock_async[p]});
    endtask
    task automatic rnd_pass(input int n);
        repeat (n) for (int p = 0; p < 4; p++) begin
            d = $random(seed);
            d[31] = 1'b1;
            d[27] = 1'b1;
            d[0] = m[p][0];
            if (m[p][17] || d[17]) d[26:24] = m[p][26:24];
            wr(p, d);
            rd(p);
            chk_out(p);
        end
    endtask
    task final_report;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // monitors and stimulus
    // ****************************************
    always @(posedge core_clk) begin
        if (rd_ph && hready) cmp(hrdata, exq.pop_front());
        rd_ph <= hsel && hready && htrans[1] && !hwrite;
        for (int p = 0; p < 4; p++) begin
            tx_cnt[p] += tx_recompute_trigger[p];
            dp_cnt[p] += dpll_frequency_clear[p];
        end
    end
    initial begin
        #200000;
        errors++;
        final_report;
    end
    initial begin
        seed = 32'hA6F6A854;
        {core_clk, arst_n, hsel, hwrite, haddr, htrans, hwdata, bypass_init} = '0;
        hsize = 3'h2;
        rx_pll_lock_async = 4'hF;
        for (int r = 0; r < 2; r++) begin
            foreach (m[p]) m[p] = CFG_RST;
            repeat (2) @(posedge core_clk);
            arst_n <= 1'b1;
            for (int p = 0; p < 4; p++) begin
                rd(p);
                chk_out(p);
            end
            exq.push_back(32'h0);
            bus(1'b0, 20'h130B0, 32'h0);
            bus(1'b1, 20'h130B8, 32'hFFFFFFFF);
            rd(0);
            rnd_pass(4);
            // model must see the new bypass level before the next write
            @(posedge core_clk) bypass_init <= 4'hF;
            @(posedge core_clk);
            rnd_pass(6);
            @(posedge core_clk) rx_pll_lock_async[1] <= 1'b0;
            repeat (6) @(posedge core_clk);
            wr(1, m[1] & ~32'h0002_0000);
            wr(1, m[1] | 32'h0003_0000);
            chk_out(1);
            @(posedge core_clk) rx_pll_lock_async[1] <= 1'b1;
            repeat (6) @(posedge core_clk);
            wr(1, m[1] | 32'h0003_0000);
            chk_out(1);
            s1 = tx_cnt[3];
            s2 = dp_cnt[3];
            wr(3, m[3] & ~32'h0004_0002);
            wr(3, m[3] | 32'h0004_0002);
            wr(3, m[3] | 32'h0004_0002);
            repeat (4) @(posedge core_clk);
            cmp(32'(tx_cnt[3] - s1), 32'h1);
            cmp(32'(dp_cnt[3] - s2), 32'h1);
            // second pass starts from a reset in mid-run
            arst_n <= 1'b0;
            bypass_init <= 4'h0;
        end
        final_report;
    end
endmodule // tb_serdes_lane_config_register
